/* verilog/ife_pkg.sv */
/*
  ife_pkg: field positions, widths and the decoded-field carrier for the
  instruction field extractor.
  assumes: bit numbers below are the msb-first numbers of the instruction
  word; the extractor converts them to vector indices itself.
*/
package ife_pkg;

  localparam int IFE_WORD_W      = 32;
  localparam int IFE_REG_W       = 5;

  // msb-first field bounds (first, last)
  localparam int IFE_DISP_FIRST  = 16;
  localparam int IFE_DISP_LAST   = 31;
  localparam int IFE_LI_FIRST    = 6;
  localparam int IFE_LI_LAST     = 29;
  localparam int IFE_LK_BIT      = 31;
  localparam int IFE_FM_FIRST    = 7;
  localparam int IFE_FM_LAST     = 14;
  localparam int IFE_IMM_FIRST   = 16;
  localparam int IFE_IMM_LAST    = 19;
  localparam int IFE_FRA_FIRST   = 11;
  localparam int IFE_FRB_FIRST   = 16;
  localparam int IFE_FRC_FIRST   = 21;
  localparam int IFE_FRD_FIRST   = 6;
  localparam int IFE_MB_FIRST    = 21;
  localparam int IFE_ME_FIRST    = 26;

  localparam int IFE_DISP_W      = IFE_DISP_LAST - IFE_DISP_FIRST + 1;
  localparam int IFE_LI_W        = IFE_LI_LAST - IFE_LI_FIRST + 1;
  localparam int IFE_FM_W        = IFE_FM_LAST - IFE_FM_FIRST + 1;
  localparam int IFE_IMM_W       = IFE_IMM_LAST - IFE_IMM_FIRST + 1;

  // branch offset gets two zero bits appended
  localparam logic [1:0]  IFE_LI_PAD     = 2'h0;
  // address of the following instruction
  localparam logic [31:0] IFE_INSTR_STEP = 32'h0000_0004;

  localparam logic [31:0] IFE_RST_WORD   = 32'h0000_0000;
  localparam logic [4:0]  IFE_RST_REG    = 5'h00;
  localparam logic [7:0]  IFE_RST_FM     = 8'h00;
  localparam logic [3:0]  IFE_RST_NIB    = 4'h0;

  typedef enum logic [3:0] {
    IFE_KIND_OTHER  = 4'h1,
    IFE_KIND_BRANCH = 4'h2,
    IFE_KIND_MTFSF  = 4'h4,
    IFE_KIND_ROTATE = 4'h8
  } ife_kind_e;

  typedef struct packed {
    logic        is_branch;
    logic        is_fp_store;
    logic        is_mtfsf;
    logic        is_rotate;
  } ife_class_s;

  typedef struct packed {
    logic [31:0] load_store_disp;
    logic [31:0] branch_long_offset;
    logic [7:0]  fp_status_field_mask;
    logic [3:0]  fp_status_nibble_value;
    logic [4:0]  fp_src_reg_first;
    logic [4:0]  fp_src_reg_second;
    logic [4:0]  fp_src_reg_third;
    logic [4:0]  fp_dest_reg;
    logic        fp_dest_valid;
    logic [4:0]  fp_store_src_reg;
    logic        fp_store_src_valid;
    logic [4:0]  rotate_mask_begin;
    logic [4:0]  rotate_mask_end;
    logic        link_update_bit;
  } ife_fields_s;

endpackage

/* verilog/ife_rot_mask.sv */
/*
  ife_rot_mask: builds the 32-bit rotate mask from begin and end positions.
  assumes: positions are msb-first; purely combinational, registered by
  the caller.
*/
`timescale 1ns/1ps
module ife_rot_mask (
  input  wire logic [4:0]  mask_begin,
  input  wire logic [4:0]  mask_end,
  output logic      [31:0] mask
);
  import ife_pkg::*;

  // begin after end means the mask wraps around bit 0
  genvar g;
  generate
    for (g = 0; g < IFE_WORD_W; g++) begin : g_bit
      localparam logic [4:0] POS = 5'(g);
      assign mask[IFE_WORD_W - 1 - g] = (mask_begin <= mask_end) ?
        (POS >= mask_begin && POS <= mask_end) :
        (POS >= mask_begin || POS <= mask_end);
    end
  endgenerate

endmodule

/* verilog/ife_extractor.sv */
/*
  ife_extractor: decodes operand and immediate fields of one 32-bit
  instruction word per accepted cycle into registered fields, link-write
  request, fp status field write enables and a rotate mask.
  assumes: fetch logic on the same clock presents instr with instr_valid
  and class flags from its opcode decode; no back-pressure.
*/
// What this block does
// - displacement bits 16-31 sign-extended to 32
// - branch offset bits 6-29, append 00, sign-extend
// - link bit zero leaves return register alone
// - link bit one writes next instruction address
// - mtfsf mask bits 7-14 select status fields
// - nibble bits 16-19 is status field data
// - fp sources at 11-15, 16-20, 21-25
// - bits 6-10 dest, or store source
// - rotate begin 21-25, end 26-30, 32-bit mask
`timescale 1ns/1ps
module ife_extractor (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire logic                instr_valid,
  input  wire logic [31:0]         instr,
  input  wire logic [31:0]         instr_addr,
  input  wire ife_pkg::ife_class_s instr_class,
  output logic                     out_valid,
  output ife_pkg::ife_fields_s     fields,
  output ife_pkg::ife_kind_e       kind,
  output logic                     return_addr_we,
  output logic [31:0]              return_addr_data,
  output logic [7:0]               fp_status_field_we,
  output logic [3:0]               fp_status_field_data,
  output logic [31:0]              rotate_mask
);
  import ife_pkg::*;

  // msb-first bit n lives at vector index 31-n
  function automatic int ife_idx(input int msb_first_bit);
    return IFE_WORD_W - 1 - msb_first_bit;
  endfunction

  // five-bit register specifier starting at msb-first bit 'first'
  function automatic logic [4:0] ife_reg(input logic [31:0] w, input int first);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < IFE_REG_W; i++) begin
      r[IFE_REG_W - 1 - i] = w[ife_idx(first + i)];
    end
    return r;
  endfunction

  logic        take;
  logic [15:0] disp_raw;
  logic [23:0] li_raw;
  logic [7:0]  fm_raw;
  logic [3:0]  imm_raw;
  logic        lk_raw;
  logic [4:0]  mb_raw;
  logic [4:0]  me_raw;
  logic [4:0]  rt_raw;
  logic [31:0] mask_raw;
  ife_fields_s fields_d;
  ife_fields_s fields_q;
  ife_kind_e   kind_d;
  ife_kind_e   kind_q;
  logic        valid_q;
  logic        ra_we_q;
  logic [31:0] ra_data_q;
  logic [7:0]  fsw_we_q;
  logic [3:0]  fsw_data_q;
  logic [31:0] mask_q;

  assign take = clk_en & instr_valid;

  assign disp_raw = instr[ife_idx(IFE_DISP_FIRST) -: IFE_DISP_W];
  assign li_raw   = instr[ife_idx(IFE_LI_FIRST) -: IFE_LI_W];
  assign fm_raw   = instr[ife_idx(IFE_FM_FIRST) -: IFE_FM_W];
  assign imm_raw  = instr[ife_idx(IFE_IMM_FIRST) -: IFE_IMM_W];
  assign lk_raw   = instr[ife_idx(IFE_LK_BIT)];
  assign mb_raw   = ife_reg(instr, IFE_MB_FIRST);
  assign me_raw   = ife_reg(instr, IFE_ME_FIRST);
  assign rt_raw   = ife_reg(instr, IFE_FRD_FIRST);

  ife_rot_mask u_rot_mask (
    .mask_begin (mb_raw),
    .mask_end   (me_raw),
    .mask       (mask_raw)
  );

  always_comb begin
    fields_d = '0;
    fields_d.load_store_disp        = {{16{disp_raw[15]}}, disp_raw};
    fields_d.branch_long_offset     = {{6{li_raw[23]}}, li_raw, IFE_LI_PAD};
    fields_d.fp_status_field_mask   = fm_raw;
    fields_d.fp_status_nibble_value = imm_raw;
    fields_d.fp_src_reg_first       = ife_reg(instr, IFE_FRA_FIRST);
    fields_d.fp_src_reg_second      = ife_reg(instr, IFE_FRB_FIRST);
    fields_d.fp_src_reg_third       = ife_reg(instr, IFE_FRC_FIRST);
    fields_d.rotate_mask_begin      = mb_raw;
    fields_d.rotate_mask_end        = me_raw;
    fields_d.link_update_bit        = lk_raw;
    // same bits name a source on stores, a destination otherwise
    if (instr_class.is_fp_store) begin
      fields_d.fp_store_src_reg   = rt_raw;
      fields_d.fp_store_src_valid = 1'b1;
    end else begin
      fields_d.fp_dest_reg   = rt_raw;
      fields_d.fp_dest_valid = 1'b1;
    end
  end

  // one class wins if fetch flags several; branch first
  always_comb begin
    if (instr_class.is_branch) begin
      kind_d = IFE_KIND_BRANCH;
    end else if (instr_class.is_mtfsf) begin
      kind_d = IFE_KIND_MTFSF;
    end else if (instr_class.is_rotate) begin
      kind_d = IFE_KIND_ROTATE;
    end else begin
      kind_d = IFE_KIND_OTHER;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      valid_q <= 1'b0;
    end else if (clk_en) begin
      valid_q <= instr_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fields_q <= '0;
      kind_q   <= IFE_KIND_OTHER;
    end else if (take) begin
      fields_q <= fields_d;
      kind_q   <= kind_d;
    end
  end

  // write request lasts one enabled cycle and holds while clk_en is low; data is held until the next write
  always_ff @(posedge clk) begin
    if (reset) begin
      ra_we_q <= 1'b0;
    end else if (clk_en) begin
      ra_we_q <= take & lk_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ra_data_q <= IFE_RST_WORD;
    end else if (take && lk_raw) begin
      ra_data_q <= instr_addr + IFE_INSTR_STEP;
    end
  end

  // enables only for mtfsf, so other fields in 7-14 never disturb status
  always_ff @(posedge clk) begin
    if (reset) begin
      fsw_we_q <= IFE_RST_FM;
    end else if (clk_en) begin
      fsw_we_q <= (take && kind_d == IFE_KIND_MTFSF) ? fm_raw : IFE_RST_FM;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fsw_data_q <= IFE_RST_NIB;
    end else if (take && kind_d == IFE_KIND_MTFSF) begin
      fsw_data_q <= imm_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= IFE_RST_WORD;
    end else if (take && kind_d == IFE_KIND_ROTATE) begin
      mask_q <= mask_raw;
    end
  end

  assign out_valid            = valid_q;
  assign fields               = fields_q;
  assign kind                 = kind_q;
  assign return_addr_we       = ra_we_q;
  assign return_addr_data     = ra_data_q;
  assign fp_status_field_we   = fsw_we_q;
  assign fp_status_field_data = fsw_data_q;
  assign rotate_mask          = mask_q;

endmodule

/* dv/ife_extractor_sva.sv */
/*
  ife_extractor_chk: port-level checks of field extraction and link write.
  assumes: bound to ife_extractor; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module ife_extractor_chk (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 clk_en,
  input wire logic                 instr_valid,
  input wire logic [31:0]          instr,
  input wire logic [31:0]          instr_addr,
  input wire ife_pkg::ife_class_s  instr_class,
  input wire logic                 out_valid,
  input wire ife_pkg::ife_fields_s fields,
  input wire logic                 return_addr_we,
  input wire logic [31:0]          return_addr_data,
  input wire logic [7:0]           fp_status_field_we,
  input wire logic [3:0]           fp_status_field_data
);
  import ife_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_acc; clk_en && instr_valid; endsequence
  sequence s_fsw; s_acc ##0 (instr_class.is_mtfsf && !instr_class.is_branch); endsequence
  chk_disp_sext:
    assert property (s_acc |=> out_valid && fields.load_store_disp ==
      {{16{$past(instr[15])}}, $past(instr[15:0])}) else $error("bad displacement");
  chk_branch_offset:
    assert property (s_acc |=> fields.branch_long_offset ==
      {{6{$past(instr[25])}}, $past(instr[25:2]), 2'h0}) else $error("bad branch offset");
  chk_link_hold:
    assert property (s_acc ##0 !instr[0] |=> !return_addr_we && $stable(return_addr_data))
    else $error("link written while link bit clear");
  chk_link_write:
    assert property (s_acc ##0 instr[0] |=> return_addr_we &&
      return_addr_data == $past(instr_addr) + 32'h4) else $error("bad link write");
  chk_mask_enables:
    assert property (s_fsw |=> fp_status_field_we == $past(instr[24:17]))
    else $error("bad status field enables");
  chk_nibble_data:
    assert property (s_fsw |=> fp_status_field_data == $past(instr[15:12]))
    else $error("bad status field data");
  chk_fp_sources:
    assert property (s_acc |=> {fields.fp_src_reg_first, fields.fp_src_reg_second,
      fields.fp_src_reg_third} == $past(instr[20:6])) else $error("bad fp sources");
  chk_dest_steer:
    assert property (s_acc |=> fields.fp_store_src_valid == $past(instr_class.is_fp_store) &&
      fields.fp_dest_valid != fields.fp_store_src_valid && (fields.fp_store_src_valid ?
      fields.fp_store_src_reg : fields.fp_dest_reg) == $past(instr[25:21]))
    else $error("bad dest or store source");
  chk_rot_bounds:
    assert property (s_acc |=> {fields.rotate_mask_begin, fields.rotate_mask_end} ==
      $past(instr[10:1])) else $error("bad rotate bounds");
endmodule
bind ife_extractor ife_extractor_chk u_chk (
  .clk(clk), .reset(reset), .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
  .instr_addr(instr_addr), .instr_class(instr_class), .out_valid(out_valid),
  .fields(fields), .return_addr_we(return_addr_we), .return_addr_data(return_addr_data),
  .fp_status_field_we(fp_status_field_we), .fp_status_field_data(fp_status_field_data)
);

/* dv/ife_fetch_model.sv */
/*
  ife_fetch_model: fetch-stage stand-in presenting words and their addresses.
  assumes: bench supplies words and classes; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module ife_fetch_model #(
  parameter logic [31:0] BASE_ADDR = 32'h0000_1000
) (
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic           clk_en,
  input  wire logic           req_valid,
  input  wire logic [31:0]    req_word,
  input  wire logic [3:0]     req_class,
  output logic                instr_valid,
  output logic [31:0]         instr,
  output logic [31:0]         instr_addr,
  output ife_pkg::ife_class_s instr_class
);
  import ife_pkg::*;
  // idle word inverted so a stale capture cannot pass as a match
  assign instr_valid = req_valid;
  assign instr       = req_valid ? req_word : ~req_word;
  assign instr_class = ife_class_s'(req_class);
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_addr <= BASE_ADDR;
    end else if (clk_en && req_valid) begin
      instr_addr <= instr_addr + 32'h0000_0004;
    end
  end
endmodule

/* dv/tb.sv */
/*
  tb: corner words then seeded random words through the extractor.
  assumes: fetch model in front, bench drives 1 ns after the rising edge.
*/
`timescale 1ns/1ps
module tb;
  import ife_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, clk_en = 1'b0, req_valid = 1'b0;
  logic [31:0] req_word = 32'h0, e_ra = 32'h0, e_rm = 32'h0;
  logic [3:0]  req_class = 4'h0, e_fd = 4'h0;
  ife_kind_e   kind;
  logic        instr_valid, out_valid, return_addr_we;
  logic [31:0] instr, instr_addr, return_addr_data, rotate_mask;
  ife_class_s  instr_class;
  ife_fields_s fields;
  logic [7:0]  fp_status_field_we;
  logic [3:0]  fp_status_field_data;
  int          err_total = 0, n_checks = 0, seed = 18483;
  logic [31:0] cw [8] = '{32'h0200_8001, 32'h03e0_7fff, 32'h01fe_f000, 32'h0000_0506,
                          32'h01ff_fffd, 32'h0000_0001, 32'h0000_0000, 32'h0000_014a};
  always #50 clk = ~clk;
  ife_fetch_model fm (.clk(clk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid),
    .req_word(req_word), .req_class(req_class), .instr_valid(instr_valid), .instr(instr),
    .instr_addr(instr_addr), .instr_class(instr_class));
  ife_extractor uut (.clk(clk), .reset(reset), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr(instr), .instr_addr(instr_addr), .instr_class(instr_class), .out_valid(out_valid),
    .fields(fields), .kind(kind), .return_addr_we(return_addr_we),
    .return_addr_data(return_addr_data), .fp_status_field_we(fp_status_field_we),
    .fp_status_field_data(fp_status_field_data), .rotate_mask(rotate_mask));
  function automatic logic [31:0] rmask(input logic [4:0] b, input logic [4:0] e);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 32; i++) begin
      if (b <= e ? (i >= b && i <= e) : (i >= b || i <= e)) m[31-i] = 1'b1;
    end
    return m;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input logic [31:0] w, input logic [3:0] c, input logic v, input logic en);
    logic acc, fs;
    logic [31:0] a;
    req_word = w;
    req_class = c;
    req_valid = v;
    clk_en = en;
    acc = v & en;
    fs = acc & c[1] & ~c[3];
    a = instr_addr;
    @(posedge clk);
    #1;
    if (acc & w[0]) e_ra = a + 32'h4;
    if (fs) e_fd = w[15:12];
    if (acc & c[0] & ~c[1] & ~c[3]) e_rm = rmask(w[10:6], w[5:1]);
    if (en) begin
      chk({30'h0, out_valid, return_addr_we}, {30'h0, acc, acc & w[0]});
      chk({24'h0, fp_status_field_we}, {24'h0, fs ? w[24:17] : 8'h0});
    end
    chk(return_addr_data, e_ra);
    chk({28'h0, fp_status_field_data}, {28'h0, e_fd});
    chk(rotate_mask, e_rm);
    if (acc) begin
      chk(fields.load_store_disp, {{16{w[15]}}, w[15:0]});
      chk(fields.branch_long_offset, {{6{w[25]}}, w[25:2], 2'h0});
      chk({17'h0, fields.fp_src_reg_first, fields.fp_src_reg_second,
           fields.fp_src_reg_third}, {17'h0, w[20:6]});
      chk({27'h0, c[2] ? fields.fp_store_src_reg : fields.fp_dest_reg}, {27'h0, w[25:21]});
      chk({30'h0, fields.fp_store_src_valid, fields.fp_dest_valid}, {30'h0, c[2], ~c[2]});
      chk({20'h0, fields.fp_status_field_mask, fields.fp_status_nibble_value},
          {20'h0, w[24:17], w[15:12]});
      chk({21'h0, fields.rotate_mask_begin, fields.rotate_mask_end, fields.link_update_bit},
          {21'h0, w[10:0]});
      // priority branch, then mtfsf, then rotate
      chk({28'h0, kind}, {28'h0, c[3] ? 4'h2 : c[1] ? 4'h4 : c[0] ? 4'h8 : 4'h1});
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 8; i++) step(cw[i], 4'h8 >> (i % 4), 1'b1, 1'b1);
    $display("test corners done");
    for (int i = 0; i < 400; i++)
      step($random(seed), 4'($random(seed)), 1'($random(seed)), 2'($random(seed)) != 2'h0);
    $display("test random done");
    give_verdict();
  end
  // about five times the expected run
  initial begin
    #(100 * 2000);
    err_total++;
    give_verdict();
  end
endmodule
